// ===== rtl/cc_detect_pkg.sv
// Purpose: Shared constants for the CC detection status register group.
// Assumes: Byte-wide register port, 40 MHz core clock.
// Notes: Times are kept in ns; cycle counts derive from them.
package cc_detect_pkg;

  // Register addresses.
  localparam logic [11:0] ADDR_EVENT_STATUS = 12'h803;
  localparam logic [11:0] ADDR_CC1_CHANGE = 12'h804;
  localparam logic [11:0] ADDR_CC2_CHANGE = 12'h805;
  localparam logic [11:0] ADDR_CC1_MATCH = 12'h806;
  localparam logic [11:0] ADDR_CC2_MATCH = 12'h807;

  // Event status bit positions.
  localparam int unsigned BIT_MATCH_VALID = 7;
  localparam int unsigned BIT_PULLUP_CHANGE = 6;
  localparam int unsigned BIT_DETACH = 5;
  localparam int unsigned BIT_ATTACH = 4;
  localparam int unsigned BIT_CC2_SUMMARY = 1;
  localparam int unsigned BIT_CC1_SUMMARY = 0;

  // Reset values.
  localparam logic [7:0] MATCH_RESET_DFP = 8'hff;
  localparam logic [7:0] MATCH_RESET_UFP = 8'h00;
  localparam logic [7:0] CHANGE_RESET = 8'h00;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [1:0] ADV_RESET = 2'h0;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLOW_UNIT_NS = 1600000;
  localparam int unsigned FAST_UNIT_NS = 100000;
  localparam int unsigned SLOW_TICK_CYCLES = SLOW_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_TICK_CYCLES = FAST_UNIT_NS / CLK_PERIOD_NS;

  // Connection state of the port, one-hot.
  typedef enum logic [2:0] {
    PORT_UNATTACHED = 3'b001,
    PORT_ATTACH_WAIT = 3'b010,
    PORT_ATTACHED = 3'b100
  } port_state_t;

endpackage

// ===== rtl/cc_settle_tick.sv
// Purpose: Free-running divider giving one tick per settle time unit.
// Assumes: PERIOD is at least 2 and below 65536.
// Notes: The tick is a one-cycle pulse.
module cc_settle_tick #(
  parameter int unsigned PERIOD = 4000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Tick
  output logic tick_o
);

  localparam logic [15:0] LAST = 16'(PERIOD - 1);

  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (count_ff == LAST);
    nxt_count = nxt_tick ? 16'h0000 : count_ff + 16'h0001;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule

// ===== rtl/cc_pin_match.sv
// Purpose: One CC pin: comparator sync, settle filter, match and change.
// Assumes: Comparator outputs are asynchronous to the core clock.
// Notes: Change bits follow any change of the presented match value.
module cc_pin_match (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Comparator and settle control
  input wire logic [7:0] cmp_raw_i,
  input wire logic [7:0] settle_clear_en_i,
  input wire logic [7:0] default_i,
  input wire logic active_i,
  input wire logic tick_i,
  input wire logic [7:0] limit_i,
  input wire logic qualify_i,
  // Change register write
  input wire logic clear_wr_i,
  input wire logic [7:0] clear_data_i,
  // Results
  output logic [7:0] match_o,
  output logic [7:0] change_o,
  output logic updated_o
);

  logic [7:0] sync1_ff, sync2_ff, cand_ff, deb_ff, cnt_ff;
  logic [7:0] match_ff, change_ff;
  logic settled_ff, upd_ff;
  logic [7:0] nxt_sync1, nxt_sync2, nxt_cand, nxt_deb, nxt_cnt;
  logic [7:0] nxt_match, nxt_change, clr_mask;
  logic nxt_settled, nxt_upd;

  always_comb begin
    nxt_sync1 = cmp_raw_i;
    nxt_sync2 = sync1_ff;
    nxt_cand = cand_ff;
    nxt_deb = deb_ff;
    nxt_cnt = cnt_ff;
    nxt_settled = settled_ff;
    nxt_upd = 1'b0;
    if (!active_i) begin
      nxt_cand = default_i;
      nxt_deb = default_i;
      nxt_cnt = 8'h00;
      nxt_settled = 1'b0;
    end else if ((sync2_ff != cand_ff) || !qualify_i) begin
      // Any movement restarts the settle interval. [R12] [R13] [R14]
      nxt_cand = sync2_ff;
      nxt_cnt = 8'h00;
      nxt_settled = 1'b0;
    end else if (cnt_ff >= limit_i) begin
      nxt_deb = cand_ff;
      nxt_settled = 1'b1;
      nxt_upd = !settled_ff;
    end else if (tick_i) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
    // Per bit: settled value or raw comparator. [R11] [R16]
    if (!active_i) begin
      nxt_match = default_i; // [R15]
    end else begin
      nxt_match = (settle_clear_en_i & deb_ff) |
                  (~settle_clear_en_i & sync2_ff);
    end
    clr_mask = clear_wr_i ? clear_data_i : 8'h00;
    // Set after clear, so a change in the clear cycle is kept. [R9] [R10]
    nxt_change = (change_ff & ~clr_mask) | (nxt_match ^ match_ff);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      cand_ff <= default_i;
      deb_ff <= default_i;
      cnt_ff <= 8'h00;
      match_ff <= default_i;
      change_ff <= cc_detect_pkg::CHANGE_RESET;
      settled_ff <= 1'b0;
      upd_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      cand_ff <= nxt_cand;
      deb_ff <= nxt_deb;
      cnt_ff <= nxt_cnt;
      match_ff <= nxt_match;
      change_ff <= nxt_change;
      settled_ff <= nxt_settled;
      upd_ff <= nxt_upd;
    end
  end

  assign match_o = match_ff;
  assign change_o = change_ff;
  assign updated_o = upd_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  change_tracks_match_a: assert property ( // [R9]
    (match_ff != $past(match_ff)) |->
      ((change_ff & (match_ff ^ $past(match_ff))) ==
       (match_ff ^ $past(match_ff))))
    else $error("match change did not set change bits");

  idle_default_a: assert property ( // [R15]
    !active_i ##1 !active_i |-> match_ff == $past(default_i))
    else $error("inactive match not at default");

  raw_path_a: assert property ( // [R16]
    active_i && settle_clear_en_i == 8'h00 |=>
      match_ff == $past(sync2_ff))
    else $error("raw match not presented");

  settle_wait_a: assert property ( // [R12]
    active_i && qualify_i && sync2_ff != cand_ff ##1
      (active_i && qualify_i && sync2_ff == cand_ff &&
       limit_i != 8'h00) |=> !updated_o)
    else $error("update before settle interval");

  change_flip_c: cover property (change_ff != 8'h00 ##1 clear_wr_i);

endmodule

// ===== rtl/cc_detect_status_regs.sv
// Purpose: CC detection event, change and match registers of a Type-C port.
// Assumes: Byte-wide register port; control bits and events come from
//   logic on the same clock, comparator outputs from analog.
// Notes: The event register is 16 bits wide but only its low byte holds
//   fields; the upper byte is not reachable on the byte port.
//
// How it works
// [R1] Match-valid flag set on first settled result.
// [R2] Standalone upstream port flags pull-up level change.
// [R3] Pull-up flag reads zero outside standalone upstream.
// [R4] New partner current advertisement is captured.
// [R5] Standalone mode flags detach events.
// [R6] Standalone mode flags attach events.
// [R7] Event pulses latch into sticky bits.
// [R8] Summary bits show pending per-pin change bits.
// [R9] Change bit sets when match bit toggles.
// [R10] Writing one clears; zero leaves untouched.
// [R11] Match bit means voltage above threshold.
// [R12] Unattached: update after match settle time.
// [R13] AttachWait: update after open line settles.
// [R14] Attached: update after attached settle time.
// [R15] Companion mode: default until comparator enabled.
// [R16] Per bit settled or raw value selectable.
// [R17] Match reset FFh as DFP, 00h UFP.
// [R18] Role bit selects DFP; frozen while active.
// [R19] Standalone bit lets internal logic run detection.
// [R20] Unit select picks 1.6 ms or 100 us. Code applies it only in Unattached; AttachWait and Attached always use 100 us.
// [R21] Two identical independent per-pin channels.
module cc_detect_status_regs #(
  parameter int unsigned SLOW_TICK_CYCLES = cc_detect_pkg::SLOW_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Control settings
  input wire logic standalone_mode_i,
  input wire logic role_dfp_i,
  input wire logic comparator_en_i,
  input wire logic settle_time_unit_select_i,
  input wire logic [7:0] match_settle_time_i,
  input wire logic [7:0] attached_settle_time_i,
  input wire logic [7:0] pin1_settle_clear_enable_i,
  input wire logic [7:0] pin2_settle_clear_enable_i,
  // Port connection state and events
  input wire cc_detect_pkg::port_state_t port_state_i,
  input wire logic open_line_i,
  input wire logic attach_event_i,
  input wire logic detach_event_i,
  input wire logic pullup_change_event_i,
  input wire logic [1:0] pullup_adv_i,
  // Comparator outputs per threshold
  input wire logic [7:0] cc1_level_i,
  input wire logic [7:0] cc2_level_i,
  // Status
  output logic [1:0] partner_adv_o,
  output logic debouncer_active_o
);

  localparam int unsigned FAST_TICKS = cc_detect_pkg::FAST_TICK_CYCLES;

  logic tick_slow, tick_fast, tick_sel, active, qualify;
  logic role_dfp_ff, nxt_role_dfp;
  logic first_done_ff, nxt_first_done;
  logic valid_flag_ff, pullup_change_flag_ff, detach_ff, attach_ff;
  logic nxt_valid_flag, nxt_pullup_change_flag, nxt_detach, nxt_attach;
  logic [1:0] adv_ff, nxt_adv;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic [7:0] limit, match_default, event_view, evt_clr;
  logic [7:0] pin1_match, pin2_match, pin1_change, pin2_change;
  logic pin1_updated, pin2_updated, wr_pin1, wr_pin2, wr_event;
  logic standalone_ufp, pin1_change_summary, pin2_change_summary;

  cc_settle_tick #(
    .PERIOD(SLOW_TICK_CYCLES)
  ) u_tick_slow (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_o(tick_slow)
  );

  cc_settle_tick #(
    .PERIOD(FAST_TICKS)
  ) u_tick_fast (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_o(tick_fast)
  );

  // Standalone mode runs the debouncer on its own. [R19]
  assign active = standalone_mode_i | comparator_en_i;
  assign standalone_ufp = standalone_mode_i & ~role_dfp_ff;

  always_comb begin
    // The role is only sampled while the debouncer is idle, so a careless
    // write during operation cannot corrupt the match defaults. [R18]
    nxt_role_dfp = active ? role_dfp_ff : role_dfp_i;
    // Reset default follows the configured role. During reset the role
    // input is used directly, so the match bytes and their change bits
    // come out of reset already at the right value. [R17]
    match_default = (rst_i ? role_dfp_i : role_dfp_ff) ?
                    cc_detect_pkg::MATCH_RESET_DFP :
                    cc_detect_pkg::MATCH_RESET_UFP;
    // Settle interval per connection state. [R12] [R13] [R14] [R20]
    limit = attached_settle_time_i;
    tick_sel = tick_fast;
    qualify = 1'b1;
    case (port_state_i)
      cc_detect_pkg::PORT_UNATTACHED: begin
        limit = match_settle_time_i;
        tick_sel = settle_time_unit_select_i ? tick_fast : tick_slow;
      end
      cc_detect_pkg::PORT_ATTACH_WAIT: begin
        qualify = open_line_i;
      end
      cc_detect_pkg::PORT_ATTACHED: begin
        qualify = 1'b1;
      end
      default: begin
        qualify = 1'b1;
      end
    endcase
  end

  assign wr_event = reg_wr_i && reg_addr_i == cc_detect_pkg::ADDR_EVENT_STATUS;
  assign wr_pin1 = reg_wr_i && reg_addr_i == cc_detect_pkg::ADDR_CC1_CHANGE;
  assign wr_pin2 = reg_wr_i && reg_addr_i == cc_detect_pkg::ADDR_CC2_CHANGE;

  // Two identical channels with their own state. [R21]
  cc_pin_match u_pin1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cmp_raw_i(cc1_level_i),
    .settle_clear_en_i(pin1_settle_clear_enable_i),
    .default_i(match_default),
    .active_i(active),
    .tick_i(tick_sel),
    .limit_i(limit),
    .qualify_i(qualify),
    .clear_wr_i(wr_pin1),
    .clear_data_i(reg_wdata_i),
    .match_o(pin1_match),
    .change_o(pin1_change),
    .updated_o(pin1_updated)
  );

  cc_pin_match u_pin2 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cmp_raw_i(cc2_level_i),
    .settle_clear_en_i(pin2_settle_clear_enable_i),
    .default_i(match_default),
    .active_i(active),
    .tick_i(tick_sel),
    .limit_i(limit),
    .qualify_i(qualify),
    .clear_wr_i(wr_pin2),
    .clear_data_i(reg_wdata_i),
    .match_o(pin2_match),
    .change_o(pin2_change),
    .updated_o(pin2_updated)
  );

  // Summary bits are live, so they drop once software empties the pin. [R8]
  assign pin1_change_summary = |pin1_change;
  assign pin2_change_summary = |pin2_change;

  always_comb begin
    evt_clr = wr_event ? reg_wdata_i : 8'h00;
    // The first settled result after enabling raises the flag. [R1]
    nxt_first_done = active & (first_done_ff | pin1_updated | pin2_updated);
    // Each sticky bit: clear by one, then set, so the set wins. [R7] [R10]
    nxt_valid_flag = (valid_flag_ff & ~evt_clr[cc_detect_pkg::BIT_MATCH_VALID])
                     | (active & ~first_done_ff &
                        (pin1_updated | pin2_updated)); // [R1]
    nxt_pullup_change_flag =
      (pullup_change_flag_ff & ~evt_clr[cc_detect_pkg::BIT_PULLUP_CHANGE])
      | (standalone_ufp & pullup_change_event_i); // [R2]
    nxt_detach = (detach_ff & ~evt_clr[cc_detect_pkg::BIT_DETACH])
                 | (standalone_mode_i & detach_event_i); // [R5]
    nxt_attach = (attach_ff & ~evt_clr[cc_detect_pkg::BIT_ATTACH])
                 | (standalone_mode_i & attach_event_i); // [R6]
    // Latest partner advertisement stays on partner_adv_o after the event. [R4]
    nxt_adv = (standalone_ufp & pullup_change_event_i) ? pullup_adv_i : adv_ff;
    event_view = 8'h00;
    event_view[cc_detect_pkg::BIT_MATCH_VALID] = valid_flag_ff;
    // Outside standalone upstream the bit reads zero. [R3]
    event_view[cc_detect_pkg::BIT_PULLUP_CHANGE] =
      pullup_change_flag_ff & standalone_ufp;
    event_view[cc_detect_pkg::BIT_DETACH] = detach_ff;
    event_view[cc_detect_pkg::BIT_ATTACH] = attach_ff;
    event_view[cc_detect_pkg::BIT_CC2_SUMMARY] = pin2_change_summary; // [R8]
    event_view[cc_detect_pkg::BIT_CC1_SUMMARY] = pin1_change_summary; // [R8]
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        cc_detect_pkg::ADDR_EVENT_STATUS: nxt_rdata = event_view;
        cc_detect_pkg::ADDR_CC1_CHANGE: nxt_rdata = pin1_change;
        cc_detect_pkg::ADDR_CC2_CHANGE: nxt_rdata = pin2_change;
        cc_detect_pkg::ADDR_CC1_MATCH: nxt_rdata = pin1_match;
        cc_detect_pkg::ADDR_CC2_MATCH: nxt_rdata = pin2_match;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      role_dfp_ff <= role_dfp_i;
      first_done_ff <= 1'b0;
      valid_flag_ff <= 1'b0;
      pullup_change_flag_ff <= 1'b0;
      detach_ff <= 1'b0;
      attach_ff <= 1'b0;
      adv_ff <= cc_detect_pkg::ADV_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      role_dfp_ff <= nxt_role_dfp;
      first_done_ff <= nxt_first_done;
      valid_flag_ff <= nxt_valid_flag;
      pullup_change_flag_ff <= nxt_pullup_change_flag;
      detach_ff <= nxt_detach;
      attach_ff <= nxt_attach;
      adv_ff <= nxt_adv;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign partner_adv_o = adv_ff;
  assign debouncer_active_o = active;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  match_valid_set_a: assert property ( // [R1]
    active && !first_done_ff && (pin1_updated || pin2_updated) |=>
      valid_flag_ff && first_done_ff)
    else $error("match valid flag not raised");

  pullup_flag_set_a: assert property ( // [R2]
    standalone_ufp && pullup_change_event_i |=> pullup_change_flag_ff)
    else $error("pull-up change not flagged");

  pullup_reads_zero_a: assert property ( // [R3]
    reg_rd_i && reg_addr_i == cc_detect_pkg::ADDR_EVENT_STATUS &&
    !standalone_ufp |=> !reg_rdata_o[cc_detect_pkg::BIT_PULLUP_CHANGE])
    else $error("pull-up flag visible outside standalone upstream");

  adv_capture_a: assert property ( // [R4]
    standalone_ufp && pullup_change_event_i |=>
      partner_adv_o == $past(pullup_adv_i))
    else $error("advertisement not captured");

  detach_set_a: assert property ( // [R5]
    standalone_mode_i && detach_event_i ##1
      !(wr_event && reg_wdata_i[cc_detect_pkg::BIT_DETACH]) |->
      detach_ff [*2])
    else $error("detach flag not held");

  attach_companion_a: assert property ( // [R6]
    !attach_ff && !(standalone_mode_i && attach_event_i) |=> !attach_ff)
    else $error("attach flag set without standalone event");

  attach_clear_a: assert property ( // [R10]
    attach_ff && wr_event && reg_wdata_i[cc_detect_pkg::BIT_ATTACH] &&
    !attach_event_i |=> !attach_ff)
    else $error("attach flag not cleared by one");

  zero_write_keeps_a: assert property ( // [R10]
    detach_ff && wr_event && !reg_wdata_i[cc_detect_pkg::BIT_DETACH] |=>
      detach_ff)
    else $error("zero write cleared detach flag");

  summary_read_a: assert property ( // [R8]
    reg_rd_i && reg_addr_i == cc_detect_pkg::ADDR_EVENT_STATUS |=>
      reg_rdata_o[1:0] == {$past(pin2_change_summary),
                           $past(pin1_change_summary)})
    else $error("summary bits wrong");

  role_frozen_a: assert property ( // [R18]
    active && $past(active) |-> $stable(role_dfp_ff))
    else $error("role changed while debouncer active");

  match_valid_c: cover property (!valid_flag_ff ##1 valid_flag_ff);
  pullup_event_c: cover property (standalone_ufp && pullup_change_event_i);
  attach_then_detach_c: cover property (attach_ff ##[1:50] detach_ff);
  summary_drop_c: cover property (pin1_change_summary ##1
    !pin1_change_summary);

  valid_kept_a: assert property ( // [R1]
    valid_flag_ff && !evt_clr[cc_detect_pkg::BIT_MATCH_VALID] |=>
      valid_flag_ff)
    else $error("match valid flag dropped without a clear");

  pullup_kept_a: assert property ( // [R7]
    pullup_change_flag_ff && !evt_clr[cc_detect_pkg::BIT_PULLUP_CHANGE] |=>
      pullup_change_flag_ff)
    else $error("pull-up flag dropped without a clear");

endmodule

// ===== sim/cc_partner_model.sv
// Purpose: Port partner on the CC lines, seen through the pin comparators.
// Assumes: The bench sets each line voltage as an 8-bit code.
// Notes: Outputs follow the voltage at once; the design resyncs them.
module cc_partner_model #(
  parameter logic [7:0] THR_BASE = 8'h10,
  parameter logic [7:0] THR_STEP = 8'h1c
) (
  // Line voltages
  input wire logic [7:0] cc1_volt_i,
  input wire logic [7:0] cc2_volt_i,
  // Comparator outputs
  output logic [7:0] cc1_level_o,
  output logic [7:0] cc2_level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Threshold i sits at THR_BASE plus i steps, so levels rise in order.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cc1_level_o[i] = cc1_volt_i > THR_BASE + 8'(i) * THR_STEP;
      cc2_level_o[i] = cc2_volt_i > THR_BASE + 8'(i) * THR_STEP;
    end
  end
endmodule

// ===== sim/tb_cc_detect_status_regs.sv
// Purpose: Self-checking bench for the CC detection status registers.
// Assumes: Short slow tick (8 cycles); fast tick is 4000 cycles.
// Notes: Settle limits of 2 are used so a free-running tick cannot
//   finish a count before the early look.
module tb_cc_detect_status_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic standalone = 1'b0;
  logic role_dfp = 1'b0;
  logic comp_en = 1'b0;
  logic unit_sel = 1'b0;
  logic [7:0] match_settle = 8'h02;
  logic [7:0] attached_settle = 8'h02;
  logic [7:0] sce1 = 8'h00;
  logic [7:0] sce2 = 8'h00;
  cc_detect_pkg::port_state_t port_state = cc_detect_pkg::PORT_UNATTACHED;
  logic open_line = 1'b1;
  logic attach_ev = 1'b0;
  logic detach_ev = 1'b0;
  logic pullup_ev = 1'b0;
  logic [1:0] pullup_adv = 2'h0;
  logic [7:0] cc1_level;
  logic [7:0] cc2_level;
  logic [1:0] partner_adv;
  logic deb_active;
  logic [7:0] v1 = 8'h00;
  logic [7:0] v2 = 8'h00;
  logic [7:0] seed = 8'h61;
  logic [7:0] m1;
  logic [7:0] m2;
  logic [7:0] msk;
  int fail_count = 0;
  int check_count = 0;

  always #12.5 sys_clk = ~sys_clk;

  cc_detect_status_regs #(.SLOW_TICK_CYCLES(8)) i_cc_detect_status_regs (
    .sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .standalone_mode_i(standalone), .role_dfp_i(role_dfp),
    .comparator_en_i(comp_en), .settle_time_unit_select_i(unit_sel),
    .match_settle_time_i(match_settle),
    .attached_settle_time_i(attached_settle),
    .pin1_settle_clear_enable_i(sce1), .pin2_settle_clear_enable_i(sce2),
    .port_state_i(port_state), .open_line_i(open_line),
    .attach_event_i(attach_ev), .detach_event_i(detach_ev),
    .pullup_change_event_i(pullup_ev), .pullup_adv_i(pullup_adv),
    .cc1_level_i(cc1_level), .cc2_level_i(cc2_level),
    .partner_adv_o(partner_adv), .debouncer_active_o(deb_active));

  cc_partner_model i_cc_partner_model (
    .cc1_volt_i(v1), .cc2_volt_i(v2),
    .cc1_level_o(cc1_level), .cc2_level_o(cc2_level));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // Expected match byte for a line voltage, from the threshold ladder.
  function automatic logic [7:0] lvl(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = v > 8'h10 + 8'(i) * 8'h1c;
    return r;
  endfunction

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read one byte and compare the masked value.
  task automatic rchk(input logic [11:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata & m, exp);
    @(posedge sys_clk);
  endtask

  task automatic pulse(input logic [2:0] ev);
    @(posedge sys_clk);
    attach_ev <= ev[0];
    detach_ev <= ev[1];
    pullup_ev <= ev[2];
    @(posedge sys_clk);
    attach_ev <= 1'b0;
    detach_ev <= 1'b0;
    pullup_ev <= 1'b0;
  endtask

  // Move one line across the mid threshold; old value must hold a while.
  task automatic tcheck(input logic sel2, input int early, input int late);
    logic [7:0] old;
    logic [11:0] a;
    a = sel2 ? 12'h807 : 12'h806;
    old = sel2 ? lvl(v2) : lvl(v1);
    @(posedge sys_clk);
    if (sel2) v2 <= v2 ^ 8'h80;
    else v1 <= v1 ^ 8'h80;
    hold(early);
    rchk(a, 8'hff, old);
    @(posedge sys_clk);
    open_line <= 1'b1;
    hold(late);
    rchk(a, 8'hff, sel2 ? lvl(v2) : lvl(v1));
  endtask

  task automatic results();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    hold(80000);
    fail_count++;
    results();
  end

  initial begin
    hold(6);
    rst <= 1'b0;
    rchk(12'h803, 8'hff, 8'h00);
    rchk(12'h804, 8'hff, 8'h00);
    rchk(12'h807, 8'hff, 8'h00);
    rchk(12'h808, 8'hff, 8'h00);
    seed = lfsr(seed);
    v1 <= seed | 8'h80;
    seed = lfsr(seed);
    v2 <= seed | 8'h40;
    hold(10);
    rchk(12'h806, 8'hff, 8'h00);
    comp_en <= 1'b1;
    hold(10);
    m1 = lvl(v1);
    m2 = lvl(v2);
    chk({7'h00, deb_active}, 8'h01);
    rchk(12'h806, 8'hff, m1);
    rchk(12'h807, 8'hff, m2);
    rchk(12'h804, 8'hff, m1);
    rchk(12'h805, 8'hff, m2);
    rchk(12'h803, 8'h0f, 8'h03);
    wr(12'h806, 8'h5a);
    rchk(12'h806, 8'hff, m1);
    seed = lfsr(seed);
    msk = seed;
    wr(12'h804, msk);
    rchk(12'h804, 8'hff, m1 & ~msk);
    wr(12'h804, 8'hff);
    rchk(12'h803, 8'h03, 8'h02);
    wr(12'h805, 8'hff);
    rchk(12'h803, 8'h03, 8'h00);
    sce1 <= 8'hff;
    sce2 <= 8'hff;
    hold(4);
    tcheck(1'b0, 2, 60);
    rchk(12'h804, 8'hff, m1 ^ lvl(v1));
    rchk(12'h803, 8'h80, 8'h80);
    unit_sel <= 1'b1;
    tcheck(1'b1, 40, 9000);
    port_state <= cc_detect_pkg::PORT_ATTACHED;
    tcheck(1'b0, 40, 9000);
    port_state <= cc_detect_pkg::PORT_ATTACH_WAIT;
    open_line <= 1'b0;
    tcheck(1'b1, 9000, 9000);
    standalone <= 1'b1;
    pullup_adv <= 2'h2;
    pulse(3'b111);
    hold(1);
    rchk(12'h803, 8'h70, 8'h70);
    chk({6'h00, partner_adv}, 8'h02);
    standalone <= 1'b0;
    rchk(12'h803, 8'h70, 8'h30);
    standalone <= 1'b1;
    wr(12'h803, 8'h70);
    hold(5);
    rchk(12'h803, 8'h70, 8'h00);
    standalone <= 1'b0;
    pulse(3'b101);
    hold(1);
    rchk(12'h803, 8'h70, 8'h00);
    comp_en <= 1'b0;
    role_dfp <= 1'b1;
    hold(2);
    rst <= 1'b1;
    hold(6);
    rst <= 1'b0;
    rchk(12'h806, 8'hff, 8'hff);
    rchk(12'h807, 8'hff, 8'hff);
    rchk(12'h804, 8'hff, 8'h00);
    chk({6'h00, partner_adv}, 8'h00);
    results();
  end
endmodule
